// ==== include/adc_cal_pkg.sv ====
package adc_cal_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_FILTER = 8'h04;
   localparam logic [7:0] OFS_OFFSET = 8'h08;
   localparam logic [7:0] OFS_GAIN   = 8'h0C;
   localparam logic [7:0] OFS_RESULT = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // Field positions
   localparam int MODE_LSB     = 0;
   localparam int MODE_W       = 3;
   localparam int FMT_BIT      = 3;
   localparam int CHOP_BIT     = 15;
   localparam int DEC_LSB      = 0;
   localparam int DEC_W        = 8;

   // Reset values
   localparam logic [15:0] FILTER_RST = 16'h0007;
   localparam logic [2:0]  MODE_RST   = 3'h0;

   // Output periods per calibration stage
   localparam int PERIODS_CHOP_OFF = 3;
   localparam int PERIODS_CHOP_ON  = 2;

   // Decimation base: one filter output every (factor+1)*DEC_BASE modulator samples
   localparam int DEC_BASE = 4;

   // Gain of unity in 1.15 format
   localparam logic [15:0] GAIN_UNITY = 16'h8000;
   localparam logic [15:0] FULL_SCALE = 16'h7FFF;

   // Converter mode codes
   typedef enum logic [2:0] {
      MODE_IDLE     = 3'h0,
      MODE_CONVERT  = 3'h1,
      MODE_SELF_OFS = 3'h4,
      MODE_SELF_GN  = 3'h5,
      MODE_SYS_OFS  = 3'h6,
      MODE_SYS_GN   = 3'h7
   } conv_mode_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CONV = 4'b0010,
      ST_CAL1 = 4'b0100,
      ST_CAL2 = 4'b1000
   } seq_state_e;

   // Front-end sample with its valid strobe
   typedef struct packed {
      logic        valid;
      logic [23:0] data;
   } sample_s;

   // Coefficient set
   typedef struct packed {
      logic [23:0] offset;
      logic [15:0] gain;
   } coeff_s;

endpackage

// ==== core/result_fifo.sv ====
`timescale 1ns/1ps
module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign push     = in_valid && in_ready;
   assign pop      = out_valid && out_ready;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Registered read data: next head loads after each pop or fresh entry
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (!out_valid || pop) begin
         if (cnt_q > (AW+1)'(pop ? 1 : 0)) begin
            out_valid <= 1'b1;
            out_data  <= mem_q[pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q];
         end else begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule

// ==== core/adc_cal_core.sv ====
`timescale 1ns/1ps
// How it works
// - Filter output averaged if chopping, offset subtracted, gain applied, rounded, saturated.
// - Coefficients load factory values at power-on reset.
// - Software coefficient writes only take effect while the converter is idle.
// - Offset or gain calibration via the mode field overwrites its coefficient.
// - Self calibration uses internal zero and full-scale inputs.
// - System calibration uses external zero and full-scale inputs.
// - Offset calibration lasts three output periods, two when chopping.
// - Gain calibration runs two stages, twice the offset duration.
// - Starting calibration aborts any conversion without delivering its result.
// - Calibration runs at the update rate in the filter register.
// - Completed calibration returns the mode to idle.
module adc_cal_core #(
   parameter logic [23:0] FACTORY_OFFSET = 24'h000000,
   parameter logic [15:0] FACTORY_GAIN   = 16'h8000,
   parameter int          FIFO_DEPTH     = 4
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  nrst,
   // Wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o,
   // Front end
   input  wire adc_cal_pkg::sample_s  ext_sample,
   input  wire adc_cal_pkg::sample_s  int_sample,
   output logic                       use_internal,
   output logic                       ref_full_scale,
   output logic                       chop_phase,
   // Result stream
   output logic                       res_valid,
   input  wire logic                  res_ready,
   output logic [15:0]                res_data
);
   logic [2:0]   mode_q;
   logic [15:0]  filter_q;
   adc_cal_pkg::coeff_s coef_q;
   adc_cal_pkg::seq_state_e st_q;
   logic [9:0]   dec_cnt_q;
   logic [1:0]   per_cnt_q;
   logic signed [33:0] acc_q;
   logic signed [33:0] sum_all;
   logic [23:0]  smp;
   logic [10:0]  n_samp;
   logic [23:0]  zero_q;
   logic         half_q;
   logic         dropped_q;
   logic [23:0]  prev_q;
   logic         wb_hit;
   logic         wb_wr;
   logic         chop;
   logic         cal_kind;
   logic         cal_gain;
   logic         cal_start;
   logic         period_end;
   logic         stage_end;
   logic [1:0]   periods;
   logic [23:0]  filt;
   logic         filt_v;
   logic [15:0]  corr;
   logic         f_valid;
   logic         f_ready;
   logic [15:0]  f_data;

   assign chop     = filter_q[adc_cal_pkg::CHOP_BIT];
   assign wb_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr    = wb_hit && wb_we_i && wb_sel_i[0];
   assign cal_kind = mode_q[2];
   assign cal_gain = mode_q[0];
   assign periods  = chop ? 2'(adc_cal_pkg::PERIODS_CHOP_ON)
                          : 2'(adc_cal_pkg::PERIODS_CHOP_OFF);

   // Saturating offset, gain and round to 16 bits
   function automatic logic [15:0] correct(input logic [23:0] x, input adc_cal_pkg::coeff_s c,
                                           input logic fmt);
      logic signed [24:0] d;
      logic signed [41:0] p;
      logic signed [25:0] r;
      logic        [15:0] s;
      d = $signed({x[23], x}) - $signed({c.offset[23], c.offset});
      p = d * $signed({1'b0, c.gain});
      r = 26'((p + 42'sh400000) >>> 23);
      if (r > 26'sh7FFF) s = adc_cal_pkg::FULL_SCALE;
      else if (r < -26'sh7FFF) s = ~adc_cal_pkg::FULL_SCALE + 16'h1;
      else s = r[15:0];
      correct = fmt ? {~s[15], s[14:0]} : s;
   endfunction

   // Wishbone: single-cycle ack
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_hit;
         if (wb_hit && !wb_we_i) begin
            if (wb_adr_i == adc_cal_pkg::OFS_MODE) begin
               wb_dat_o <= {29'h0, mode_q};
            end else if (wb_adr_i == adc_cal_pkg::OFS_FILTER) begin
               wb_dat_o <= {16'h0, filter_q};
            end else if (wb_adr_i == adc_cal_pkg::OFS_OFFSET) begin
               wb_dat_o <= {8'h0, coef_q.offset};
            end else if (wb_adr_i == adc_cal_pkg::OFS_GAIN) begin
               wb_dat_o <= {16'h0, coef_q.gain};
            end else if (wb_adr_i == adc_cal_pkg::OFS_RESULT) begin
               wb_dat_o <= {16'h0, f_data};
            end else if (wb_adr_i == adc_cal_pkg::OFS_STATUS) begin
               wb_dat_o <= {26'h0, dropped_q, f_valid, st_q};
            end else begin
               wb_dat_o <= 32'h0;
            end
         end
      end
   end

   assign cal_start = wb_wr && wb_adr_i == adc_cal_pkg::OFS_MODE && wb_dat_i[2];

   // Filter configuration
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         filter_q <= adc_cal_pkg::FILTER_RST;
      end else if (wb_wr && wb_adr_i == adc_cal_pkg::OFS_FILTER) begin
         filter_q <= wb_dat_i[15:0];
      end
   end

   // Decimation: one filter output per (factor+1)*base samples, the mean of all of them
   assign smp     = use_internal ? int_sample.data : ext_sample.data;
   assign n_samp  = 11'((filter_q[7:0] + 11'd1) * adc_cal_pkg::DEC_BASE);
   assign sum_all = acc_q + 34'($signed(smp));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dec_cnt_q <= '0;
         acc_q     <= '0;
      end else if (st_q == adc_cal_pkg::ST_IDLE || cal_start) begin
         dec_cnt_q <= '0;
         acc_q     <= '0;
      end else if (use_internal ? int_sample.valid : ext_sample.valid) begin
         if (dec_cnt_q == 10'(n_samp - 11'd1)) begin
            dec_cnt_q <= '0;
            acc_q     <= '0;
         end else begin
            dec_cnt_q <= dec_cnt_q + 10'd1;
            acc_q     <= sum_all;
         end
      end
   end

   assign filt_v = (st_q != adc_cal_pkg::ST_IDLE) && !cal_start
                   && (use_internal ? int_sample.valid : ext_sample.valid)
                   && dec_cnt_q == 10'(n_samp - 11'd1);
   assign filt   = 24'(sum_all / $signed({23'h0, n_samp}));

   // Chop averaging: pairs of opposite-phase outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_q     <= '0;
         half_q     <= 1'b0;
         chop_phase <= 1'b0;
      end else if (st_q == adc_cal_pkg::ST_IDLE || cal_start) begin
         half_q     <= 1'b0;
         chop_phase <= 1'b0;
      end else if (filt_v) begin
         prev_q     <= filt;
         half_q     <= chop ? !half_q : 1'b0;
         chop_phase <= chop ? !chop_phase : 1'b0;
      end
   end

   assign period_end = filt_v && (!chop || half_q);
   assign stage_end  = period_end && per_cnt_q == periods - 2'd1;
   assign corr = correct(chop ? 24'(($signed({prev_q[23], prev_q}) + $signed({filt[23], filt})) >>> 1)
                              : filt, coef_q, filter_q[adc_cal_pkg::FMT_BIT]);

   // Sequencer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q           <= adc_cal_pkg::ST_IDLE;
         mode_q         <= adc_cal_pkg::MODE_RST;
         per_cnt_q      <= '0;
         use_internal   <= 1'b0;
         ref_full_scale <= 1'b0;
      end else if (wb_wr && wb_adr_i == adc_cal_pkg::OFS_MODE) begin
         mode_q         <= wb_dat_i[2:0];
         per_cnt_q      <= '0;
         use_internal   <= wb_dat_i[2] && !wb_dat_i[1];
         ref_full_scale <= 1'b0;
         if (wb_dat_i[2]) st_q <= adc_cal_pkg::ST_CAL1;
         else if (wb_dat_i[2:0] == adc_cal_pkg::MODE_CONVERT) st_q <= adc_cal_pkg::ST_CONV;
         else st_q <= adc_cal_pkg::ST_IDLE;
      end else if ((st_q == adc_cal_pkg::ST_CAL1 || st_q == adc_cal_pkg::ST_CAL2) && period_end) begin
         per_cnt_q <= stage_end ? 2'd0 : per_cnt_q + 2'd1;
         if (stage_end) begin
            if (st_q == adc_cal_pkg::ST_CAL1 && cal_gain) begin
               st_q           <= adc_cal_pkg::ST_CAL2;
               ref_full_scale <= 1'b1;
            end else begin
               st_q           <= adc_cal_pkg::ST_IDLE;
               mode_q         <= adc_cal_pkg::MODE_IDLE;
               use_internal   <= 1'b0;
               ref_full_scale <= 1'b0;
            end
         end
      end
   end

   // Coefficients: zero-scale reading kept aside for the gain stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         coef_q.offset <= FACTORY_OFFSET;
         coef_q.gain   <= FACTORY_GAIN;
         zero_q        <= '0;
      end else if (st_q == adc_cal_pkg::ST_IDLE && wb_wr && wb_adr_i == adc_cal_pkg::OFS_OFFSET) begin
         coef_q.offset <= wb_dat_i[23:0];
      end else if (st_q == adc_cal_pkg::ST_IDLE && wb_wr && wb_adr_i == adc_cal_pkg::OFS_GAIN) begin
         coef_q.gain   <= wb_dat_i[15:0];
      end else if (stage_end && st_q == adc_cal_pkg::ST_CAL1) begin
         if (cal_gain) zero_q <= filt;
         else coef_q.offset <= filt;
      end else if (stage_end && st_q == adc_cal_pkg::ST_CAL2) begin
         // System gain sees full scale in both stages: zero comes from the offset
         coef_q.gain <= gain_from_span(filt - (use_internal ? zero_q : coef_q.offset),
                                       coef_q.gain);
      end
   end

   // New gain maps the span reading to full scale, independent of the current gain; span below 1/2 saturates
   function automatic logic [15:0] gain_from_span(input logic [23:0] span, input logic [15:0] g);
      logic [39:0] num;
      logic [39:0] q;
      num = {24'h0, adc_cal_pkg::FULL_SCALE} << 23;
      q = (span[23] || span[23:14] == 10'h0) ? 40'hFFFF : num / {16'h0, span};
      gain_from_span = (q > 40'hFFFF) ? 16'hFFFF : q[15:0];
   endfunction

   // Results only in conversion mode; a full FIFO drops and flags
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dropped_q <= 1'b0;
      end else if (period_end && st_q == adc_cal_pkg::ST_CONV && !f_ready) begin
         dropped_q <= 1'b1;
      end else if (wb_hit && !wb_we_i && wb_adr_i == adc_cal_pkg::OFS_STATUS) begin
         dropped_q <= 1'b0;
      end
   end

   result_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (period_end && st_q == adc_cal_pkg::ST_CONV),
      .in_ready  (f_ready),
      .in_data   (corr),
      .out_valid (f_valid),
      .out_ready (res_ready),
      .out_data  (f_data)
   );

   assign res_valid = f_valid;
   assign res_data  = f_data;

   a_idle_after_cal: assert property (@(posedge clk) disable iff (!nrst)
      (stage_end && (st_q == adc_cal_pkg::ST_CAL2 || (st_q == adc_cal_pkg::ST_CAL1 && !cal_gain))
       && !wb_wr) |=> (mode_q == 3'h0 && st_q == adc_cal_pkg::ST_IDLE))
      else $error("calibration did not return to idle");
   a_coef_hold: assert property (@(posedge clk) disable iff (!nrst)
      (st_q != adc_cal_pkg::ST_IDLE && !stage_end) |=> $stable(coef_q))
      else $error("coefficient changed mid-run");
   a_cal_abort: assert property (@(posedge clk) disable iff (!nrst)
      cal_start |=> (st_q == adc_cal_pkg::ST_CAL1 && dec_cnt_q == 10'h0))
      else $error("calibration start did not abort conversion");
   a_no_cal_result: assert property (@(posedge clk) disable iff (!nrst)
      cal_start |-> !u_fifo.push)
      else $error("result delivered outside conversion");
   a_gain_two_stage: assert property (@(posedge clk) disable iff (!nrst)
      (stage_end && st_q == adc_cal_pkg::ST_CAL1 && cal_gain && !wb_wr)
      |=> st_q == adc_cal_pkg::ST_CAL2)
      else $error("gain calibration skipped second stage");
   a_stage_len: assert property (@(posedge clk) disable iff (!nrst)
      stage_end |-> per_cnt_q == (chop ? 2'd1 : 2'd2))
      else $error("stage length wrong");
   a_sw_write_idle: assert property (@(posedge clk) disable iff (!nrst)
      (st_q != adc_cal_pkg::ST_IDLE && wb_wr && wb_adr_i == adc_cal_pkg::OFS_GAIN && !stage_end)
      |=> $stable(coef_q.gain))
      else $error("gain written while busy");
   a_self_internal: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == adc_cal_pkg::ST_CAL1 && mode_q[2:1] == 2'b10) |-> use_internal)
      else $error("self calibration not on internal input");
   a_sys_external: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == adc_cal_pkg::ST_CAL1 && mode_q[2:1] == 2'b11) |-> !use_internal)
      else $error("system calibration not on external input");
endmodule

// ==== tb/fe_model.sv ====
`timescale 1ns/1ps
module fe_model #(
   parameter logic [23:0] INT_FULL = 24'h400000
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            nrst,
   // Path control from the core
   input  wire logic            use_internal,
   input  wire logic            ref_full_scale,
   // Level applied at the external input
   input  wire logic [23:0]     ext_level,
   // Modulator samples
   output adc_cal_pkg::sample_s ext_sample,
   output adc_cal_pkg::sample_s int_sample
);
   logic tick_q;

   // One modulator sample every second core clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= ~tick_q;
      end
   end

   // Only the selected path strobes; data outside a strobe is scrambled
   always_comb begin
      ext_sample.valid = tick_q & ~use_internal;
      ext_sample.data  = ext_sample.valid ? ext_level : ~ext_level;
      int_sample.valid = tick_q & use_internal;
      int_sample.data  = ref_full_scale ? INT_FULL : 24'h000000;
      if (!int_sample.valid) begin
         int_sample.data = ~int_sample.data;
      end
   end
endmodule

// ==== tb/adc_calibration_correction_tb_top.sv ====
`timescale 1ns/1ps
module adc_calibration_correction_tb_top;
   localparam logic [23:0] ZERO_LVL = 24'h001000;
   localparam logic [23:0] FULL_LVL = 24'h401000;
   logic                 clk;
   logic                 nrst;
   logic                 wb_cyc;
   logic                 wb_stb;
   logic                 wb_we;
   logic                 wb_ack;
   logic [7:0]           wb_adr;
   logic [31:0]          wb_wdat;
   logic [31:0]          wb_rdat;
   logic [31:0]          rd;
   adc_cal_pkg::sample_s ext_sample;
   adc_cal_pkg::sample_s int_sample;
   logic                 use_internal;
   logic                 ref_full_scale;
   logic                 chop_phase;
   logic                 chop_prev;
   logic                 res_valid;
   logic                 res_ready;
   logic [15:0]          res_data;
   logic [23:0]          ext_level;
   int                   err_count;
   int                   n_tests;
   int                   cycles;
   int                   ui_cnt;
   int                   fs_cnt;
   int                   chop_cnt;
   int                   res_cnt;

   adc_cal_core adc_cal_core_i (
      .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .ext_sample(ext_sample), .int_sample(int_sample),
      .use_internal(use_internal), .ref_full_scale(ref_full_scale),
      .chop_phase(chop_phase), .res_valid(res_valid), .res_ready(res_ready),
      .res_data(res_data));

   fe_model fe_model_i (
      .clk(clk), .nrst(nrst), .use_internal(use_internal),
      .ref_full_scale(ref_full_scale), .ext_level(ext_level),
      .ext_sample(ext_sample), .int_sample(int_sample));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Activity monitors and run limit
   always @(posedge clk) begin
      cycles++;
      if (use_internal === 1'b1) ui_cnt++;
      if (ref_full_scale === 1'b1) fs_cnt++;
      if (chop_phase !== chop_prev) chop_cnt++;
      if (res_valid === 1'b1 && res_ready === 1'b1) res_cnt++;
      chop_prev = chop_phase;
      if (cycles == 40000) begin
         err_count++;
         results();
      end
   end

   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi,
                      input string m);
      n_tests++;
      if ($isunknown(got) || got < lo || got > hi) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h", $time, m, got);
      end
   endtask

   // One classic Wishbone cycle; request held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_adr  <= adr;
      wb_wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      chk(n, 1, 49, "bus cycle not acknowledged");
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      wb(1'b1, adr, d);
   endtask

   task automatic rdc(input logic [7:0] adr, input logic [31:0] e, input string m);
      wb(1'b0, adr, 32'h0);
      chk(rd, e, e, m);
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         wb(1'b0, adc_cal_pkg::OFS_MODE, 32'h0);
         n++;
      end while (rd[2:0] !== 3'h0 && n < 400);
      chk(n, 1, 399, "mode did not return to idle");
   endtask

   // Convert at a level; the second result is judged
   task automatic conv_at(input logic [23:0] lvl, input logic [15:0] lo, input logic [15:0] hi);
      int n;
      ext_level <= lvl;
      wr(adc_cal_pkg::OFS_MODE, 32'h1);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (!(res_valid === 1'b1 && res_ready === 1'b1) && n < 3000);
      end
      chk({16'h0, res_data}, {16'h0, lo}, {16'h0, hi}, "converted result");
      wr(adc_cal_pkg::OFS_MODE, 32'h0);
      repeat (8) @(posedge clk);
   endtask

   task automatic t_reset;
      rdc(adc_cal_pkg::OFS_MODE, 32'h0, "mode after reset");
      rdc(adc_cal_pkg::OFS_FILTER, 32'h0007, "filter after reset");
      rdc(adc_cal_pkg::OFS_OFFSET, 32'h0, "factory offset");
      rdc(adc_cal_pkg::OFS_GAIN, 32'h8000, "factory gain");
      rdc(adc_cal_pkg::OFS_STATUS, 32'h1, "status after reset");
      rdc(8'h20, 32'h0, "unmapped read");
   endtask

   task automatic t_idle_write;
      wr(adc_cal_pkg::OFS_MODE, 32'h1);
      wr(adc_cal_pkg::OFS_OFFSET, 32'h123);
      rdc(adc_cal_pkg::OFS_OFFSET, 32'h0, "offset written while converting");
      wr(adc_cal_pkg::OFS_MODE, 32'h0);
      repeat (8) @(posedge clk);
      wr(adc_cal_pkg::OFS_OFFSET, 32'h123);
      rdc(adc_cal_pkg::OFS_OFFSET, 32'h123, "offset written while idle");
      wr(adc_cal_pkg::OFS_OFFSET, 32'h0);
   endtask

   // Self offset at two update rates: three output periods each
   task automatic t_self_offset;
      int p;
      wr(adc_cal_pkg::OFS_GAIN, 32'h8000);
      for (int i = 0; i < 2; i++) begin
         p = (i == 0 ? 8 : 4) * 4 * 2;
         wr(adc_cal_pkg::OFS_FILTER, i == 0 ? 32'h7 : 32'h3);
         ui_cnt = 0;
         wr(adc_cal_pkg::OFS_MODE, 32'h4);
         wait_idle();
         chk(ui_cnt, 3 * p - 6, 3 * p + 6, "self offset duration");
         rdc(adc_cal_pkg::OFS_OFFSET, 32'h0, "self offset coefficient");
      end
      wr(adc_cal_pkg::OFS_FILTER, 32'h7);
   endtask

   task automatic t_self_gain;
      ui_cnt = 0;
      fs_cnt = 0;
      wr(adc_cal_pkg::OFS_MODE, 32'h5);
      wait_idle();
      chk(ui_cnt, 6 * 64 - 8, 6 * 64 + 8, "self gain duration");
      chk(fs_cnt, 3 * 64 - 6, 3 * 64 + 6, "full-scale stage");
      rdc(adc_cal_pkg::OFS_GAIN, 32'hFFFE, "self gain coefficient");
      wr(adc_cal_pkg::OFS_GAIN, 32'h8000);
   endtask

   task automatic t_sys_cal;
      int snap;
      ext_level <= ZERO_LVL;
      wr(adc_cal_pkg::OFS_MODE, 32'h1);
      repeat (200) @(posedge clk);
      wr(adc_cal_pkg::OFS_MODE, 32'h6);
      repeat (8) @(posedge clk);
      snap = res_cnt;
      ui_cnt = 0;
      wait_idle();
      chk(res_cnt, snap, snap, "result delivered during calibration");
      rdc(adc_cal_pkg::OFS_OFFSET, {8'h0, ZERO_LVL}, "system offset");
      ext_level <= FULL_LVL;
      wr(adc_cal_pkg::OFS_MODE, 32'h7);
      rdc(adc_cal_pkg::OFS_GAIN, 32'h8000, "gain changed mid calibration");
      wait_idle();
      chk(ui_cnt, 0, 0, "internal path used in system calibration");
      rdc(adc_cal_pkg::OFS_GAIN, 32'hFFFE, "system gain");
   endtask

   task automatic t_results;
      conv_at(ZERO_LVL, 16'h0000, 16'h0000);
      conv_at(FULL_LVL, 16'h7FFE, 16'h7FFF);
      conv_at(ZERO_LVL + 24'h200000, 16'h3FFF, 16'h4001);
      conv_at(FULL_LVL + 24'h200000, 16'h7FFF, 16'h7FFF);
      wr(adc_cal_pkg::OFS_FILTER, 32'h000F);
      conv_at(ZERO_LVL, 16'h8000, 16'h8000);
      wr(adc_cal_pkg::OFS_FILTER, 32'h8007);
      chop_cnt = 0;
      conv_at(ZERO_LVL, 16'h0000, 16'h0000);
      chk(chop_cnt, 2, 1000, "chop phase idle while chopping");
      wr(adc_cal_pkg::OFS_FILTER, 32'h0007);
   endtask

   // Fill the result buffer with the reader stalled, then drain it
   task automatic t_fifo;
      res_ready <= 1'b0;
      ext_level <= ZERO_LVL;
      wr(adc_cal_pkg::OFS_MODE, 32'h1);
      repeat (600) @(posedge clk);
      wr(adc_cal_pkg::OFS_MODE, 32'h0);
      rdc(adc_cal_pkg::OFS_STATUS, 32'h31, "status with full buffer");
      rdc(adc_cal_pkg::OFS_STATUS, 32'h11, "drop flag after status read");
      res_cnt = 0;
      res_ready <= 1'b1;
      repeat (20) @(posedge clk);
      chk(res_cnt, 4, 4, "entries drained");
      rdc(adc_cal_pkg::OFS_STATUS, 32'h1, "status with empty buffer");
   endtask

   initial begin
      nrst = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_wdat = 32'h0;
      res_ready = 1'b1;
      ext_level = 24'h000000;
      chop_prev = 1'b0;
      err_count = 0;
      n_tests = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_idle_write();
      t_self_offset();
      t_self_gain();
      t_sys_cal();
      t_results();
      t_fifo();
      results();
   end
endmodule
